// >>> bench/dcpc_host_model.sv
module dcpc_host_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic data_clock,
    output logic [7:0] period,
    output logic [7:0] rises
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev_r;
    logic [7:0] cnt_r;
    ////////////////////////////////////////////////////////////////////
    // Host times the forwarded clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_r <= 1'b0;
            cnt_r <= 8'h00;
            period <= 8'h00;
            rises <= 8'h00;
        end else begin
            prev_r <= data_clock;
            cnt_r <= cnt_r + 8'h01;
            if (data_clock && !prev_r) begin
                cnt_r <= 8'h01;
                period <= cnt_r;
                rises <= rises + 8'h01;
            end
        end
    end
endmodule : dcpc_host_model

// >>> bench/test_dac_clock_phase_control.sv
module test_dac_clock_phase_control;
    timeunit 1ns;
    timeprecision 1ns;
    import dcpc_pkg::*;
    logic clock, rstn, cfg_wr, cfg_rd;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, period, rises;
    logic fclk, sclk, yclk, div_inv;
    int err_count, cmp_count;
    dcpc_top dut_u (.clock(clock), .rstn(rstn), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_rdata(cfg_rdata), .forwarded_data_clock(fclk),
        .input_sampling_clock(sclk), .datapath_sync_clock(yclk),
        .divider_invalid(div_inv));
    dcpc_host_model host_u (.clock(clock), .rstn(rstn), .data_clock(fclk),
        .period(period), .rises(rises));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("Errors %0d of %0d checks", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
            err_count++;
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clock);
        cfg_rd <= 1'b0;
        #1;
        check(cfg_rdata, exp);
    endtask : rd_reg
    task automatic commit;
        wr_reg(DCPC_ADDR_COMMIT, 8'h00);
        wr_reg(DCPC_ADDR_COMMIT, 8'h80);
    endtask : commit
    task automatic settle(input logic [7:0] per, input logic inv);
        logic [7:0] r;
        repeat (200) @(posedge clock);
        #1;
        check({7'h00, div_inv}, {7'h00, inv});
        r = rises;
        if (per != 8'h00) begin
            check(period, per);
        end else begin
            repeat (100) @(posedge clock);
            #1;
            check(rises, r);
        end
    endtask : settle
    task automatic set_div(input logic [2:0] c, input logic [7:0] per,
            input logic inv);
        wr_reg(DCPC_ADDR_DIV, {1'b0, c, 4'h0});
        commit();
        settle(per, inv);
    endtask : set_div
    task automatic phase(input logic [3:0] s, input logic [3:0] y);
        int k;
        int d;
        logic ps, py;
        wr_reg(DCPC_ADDR_PHASE, {s, y});
        commit();
        rd_reg(DCPC_ADDR_PHASE, {s, y});
        d = 99;
        for (k = 0; k < 40; k++) begin
            ps = sclk;
            py = yclk;
            @(posedge clock);
            #1;
            if (sclk && !ps) break;
        end
        if (k == 40) begin
            err_count++;
        end else begin
            if (yclk && !py) d = 0;
            for (k = 1; k < 16; k++) begin
                py = yclk;
                @(posedge clock);
                #1;
                if (yclk && !py) d = k;
            end
        end
        check(8'(d), {4'h0, y - s});
    endtask : phase
    ////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        err_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        rd_reg(DCPC_ADDR_DIV, 8'h0F);
        wr_reg(DCPC_ADDR_DIV, 8'hFF);
        rd_reg(DCPC_ADDR_DIV, 8'h7F);
        rd_reg(8'h30, 8'h00);
        set_div(DCPC_DIV_16, 8'h10, 1'b0);
        wr_reg(DCPC_ADDR_DIV, 8'h20);
        wr_reg(DCPC_ADDR_COMMIT, 8'h80);
        rd_reg(DCPC_ADDR_COMMIT, 8'h80);
        settle(8'h10, 1'b0);
        set_div(DCPC_DIV_32, 8'h20, 1'b0);
        set_div(DCPC_DIV_64, 8'h40, 1'b0);
        set_div(DCPC_DIV_OFF, 8'h00, 1'b0);
        set_div(3'h3, 8'h00, 1'b1);
        set_div(3'h5, 8'h00, 1'b1);
        set_div(3'h6, 8'h00, 1'b1);
        set_div(3'h7, 8'h00, 1'b1);
        phase(4'h0, 4'h0);
        phase(4'h0, 4'h5);
        phase(4'h3, 4'hF);
        phase(4'hF, 4'h0);
        phase(4'hA, 4'h7);
        conclude();
    end
endmodule : test_dac_clock_phase_control

// >>> pkg/dcpc_pkg.sv
package dcpc_pkg;
    localparam logic [7:0] DCPC_ADDR_DIV = 8'h22;
    localparam logic [7:0] DCPC_ADDR_PHASE = 8'h23;
    localparam logic [7:0] DCPC_ADDR_COMMIT = 8'h24;
    localparam int DCPC_DIV_LSB = 4;
    localparam int DCPC_DIV_MSB = 6;
    localparam int DCPC_RSVD_BIT = 7;
    localparam int DCPC_SAMP_LSB = 4;
    localparam int DCPC_SAMP_MSB = 7;
    localparam int DCPC_SYNC_LSB = 0;
    localparam int DCPC_SYNC_MSB = 3;
    localparam int DCPC_COMMIT_BIT = 7;
    localparam logic [3:0] DCPC_FIXED_FIXED_HIGH_READBACK = 4'hF;
    localparam logic [2:0] DCPC_DIV_OFF = 3'h0;
    localparam logic [2:0] DCPC_DIV_16 = 3'h1;
    localparam logic [2:0] DCPC_DIV_32 = 3'h2;
    localparam logic [2:0] DCPC_DIV_64 = 3'h4;
    localparam logic [5:0] DCPC_HALF_16 = 6'h08;
    localparam logic [5:0] DCPC_HALF_32 = 6'h10;
    localparam logic [5:0] DCPC_HALF_64 = 6'h20;
    localparam logic [2:0] DCPC_DIV_RST = 3'h0;
    localparam logic [3:0] DCPC_PHASE_RST = 4'h0;
    localparam int DCPC_PHASES = 16;
endpackage : dcpc_pkg

// >>> verilog/dcpc_phase_gen.sv
module dcpc_phase_gen #(
    parameter int PHASES = 16
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [$clog2(PHASES)-1:0] base_cnt,
    input wire logic [$clog2(PHASES)-1:0] phase,
    output logic clk_out
);
    localparam int W = $clog2(PHASES);
    localparam logic [W-1:0] HALF = W'(PHASES / 2);

    if (PHASES < 2 || (PHASES & (PHASES - 1)) != 0) begin : g_bad_phases
        $error("PHASES must be a power of two");
    end

    logic clk_r;
    logic clk_nxt;
    logic [W-1:0] offset;

    // High for half a period starting at the chosen phase
    always_comb begin
        offset = W'(base_cnt - phase);
        clk_nxt = offset < HALF;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clk_r <= 1'b0;
        end else begin
            clk_r <= clk_nxt;
        end
    end

    assign clk_out = clk_r;
endmodule : dcpc_phase_gen

// >>> verilog/dcpc_top.sv
module dcpc_top
    import dcpc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    output logic forwarded_data_clock,
    output logic input_sampling_clock,
    output logic datapath_sync_clock,
    output logic divider_invalid
);
    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [2:0] shd_div_r;
    logic [2:0] shd_div_nxt;
    logic [3:0] shd_samp_r;
    logic [3:0] shd_samp_nxt;
    logic [3:0] shd_sync_r;
    logic [3:0] shd_sync_nxt;
    logic commit_r;
    logic commit_nxt;
    logic [2:0] act_div_r;
    logic [2:0] act_div_nxt;
    logic [3:0] act_samp_r;
    logic [3:0] act_samp_nxt;
    logic [3:0] act_sync_r;
    logic [3:0] act_sync_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic commit_edge;

    always_comb begin
        shd_div_nxt = shd_div_r;
        shd_samp_nxt = shd_samp_r;
        shd_sync_nxt = shd_sync_r;
        commit_nxt = commit_r;
        commit_edge = 1'b0;
        if (cfg_wr && cfg_addr == DCPC_ADDR_DIV) begin
            // Reserved bit and fixed bits not stored
            shd_div_nxt = cfg_wdata[DCPC_DIV_MSB:DCPC_DIV_LSB];
        end
        if (cfg_wr && cfg_addr == DCPC_ADDR_PHASE) begin
            shd_samp_nxt = cfg_wdata[DCPC_SAMP_MSB:DCPC_SAMP_LSB];
            shd_sync_nxt = cfg_wdata[DCPC_SYNC_MSB:DCPC_SYNC_LSB];
        end
        if (cfg_wr && cfg_addr == DCPC_ADDR_COMMIT) begin
            commit_nxt = cfg_wdata[DCPC_COMMIT_BIT];
            commit_edge = cfg_wdata[DCPC_COMMIT_BIT] && !commit_r;
        end
        act_div_nxt = act_div_r;
        act_samp_nxt = act_samp_r;
        act_sync_nxt = act_sync_r;
        if (commit_edge) begin
            act_div_nxt = shd_div_r;
            act_samp_nxt = shd_samp_r;
            act_sync_nxt = shd_sync_r;
        end
        rdata_nxt = rdata_r;
        if (cfg_rd) begin
            case (cfg_addr)
                DCPC_ADDR_DIV: begin
                    rdata_nxt = {1'b0, shd_div_r, DCPC_FIXED_FIXED_HIGH_READBACK};
                end
                DCPC_ADDR_PHASE: begin
                    rdata_nxt = {shd_samp_r, shd_sync_r};
                end
                DCPC_ADDR_COMMIT: begin
                    rdata_nxt = {commit_r, 7'h00};
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shd_div_r <= DCPC_DIV_RST;
            shd_samp_r <= DCPC_PHASE_RST;
            shd_sync_r <= DCPC_PHASE_RST;
            commit_r <= 1'b0;
            act_div_r <= DCPC_DIV_RST;
            act_samp_r <= DCPC_PHASE_RST;
            act_sync_r <= DCPC_PHASE_RST;
            rdata_r <= 8'h00;
        end else begin
            shd_div_r <= shd_div_nxt;
            shd_samp_r <= shd_samp_nxt;
            shd_sync_r <= shd_sync_nxt;
            commit_r <= commit_nxt;
            act_div_r <= act_div_nxt;
            act_samp_r <= act_samp_nxt;
            act_sync_r <= act_sync_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cfg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Forwarded clock divider
    logic [5:0] fwd_cnt_r;
    logic [5:0] fwd_cnt_nxt;
    logic fwd_clk_r;
    logic fwd_clk_nxt;
    logic [5:0] half;
    logic div_valid;

    always_comb begin
        case (act_div_r)
            DCPC_DIV_16: begin
                half = DCPC_HALF_16;
                div_valid = 1'b1;
            end
            DCPC_DIV_32: begin
                half = DCPC_HALF_32;
                div_valid = 1'b1;
            end
            DCPC_DIV_64: begin
                half = DCPC_HALF_64;
                div_valid = 1'b1;
            end
            default: begin
                half = DCPC_HALF_16;
                div_valid = 1'b0;
            end
        endcase
        fwd_cnt_nxt = fwd_cnt_r;
        fwd_clk_nxt = fwd_clk_r;
        if (!div_valid || commit_edge) begin
            fwd_cnt_nxt = 6'h00;
            fwd_clk_nxt = 1'b0;
        end else if (fwd_cnt_r == 6'(half - 6'h01)) begin
            fwd_cnt_nxt = 6'h00;
            fwd_clk_nxt = !fwd_clk_r;
        end else begin
            fwd_cnt_nxt = 6'(fwd_cnt_r + 6'h01);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fwd_cnt_r <= 6'h00;
            fwd_clk_r <= 1'b0;
        end else begin
            fwd_cnt_r <= fwd_cnt_nxt;
            fwd_clk_r <= fwd_clk_nxt;
        end
    end

    assign forwarded_data_clock = fwd_clk_r;
    assign divider_invalid = (act_div_r != DCPC_DIV_OFF) && !div_valid;

    ////////////////////////////////////////////////////////////////////////
    // Phase-selected internal clocks
    logic [3:0] base_cnt_r;
    logic [3:0] base_cnt_nxt;

    always_comb begin
        base_cnt_nxt = 4'(base_cnt_r + 4'h1);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            base_cnt_r <= 4'h0;
        end else begin
            base_cnt_r <= base_cnt_nxt;
        end
    end

    dcpc_phase_gen #(.PHASES(DCPC_PHASES)) u_samp (
        .clock(clock),
        .rstn(rstn),
        .base_cnt(base_cnt_r),
        .phase(act_samp_r),
        .clk_out(input_sampling_clock)
    );

    dcpc_phase_gen #(.PHASES(DCPC_PHASES)) u_sync (
        .clock(clock),
        .rstn(rstn),
        .base_cnt(base_cnt_r),
        .phase(act_sync_r),
        .clk_out(datapath_sync_clock)
    );

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    logic [4:0] samp_quiet_r;
    logic [4:0] samp_quiet_nxt;

    // Cycles since sampling phase moved
    always_comb begin
        samp_quiet_nxt = samp_quiet_r;
        if (act_samp_nxt != act_samp_r) begin
            samp_quiet_nxt = 5'h00;
        end else if (samp_quiet_r != 5'h1F) begin
            samp_quiet_nxt = 5'(samp_quiet_r + 5'h01);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            samp_quiet_r <= 5'h00;
        end else begin
            samp_quiet_r <= samp_quiet_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_div_off;
        (act_div_r == DCPC_DIV_OFF) [*2] |-> !forwarded_data_clock;
    endproperty
    a_div_off: assert property (p_div_off) else $error("clock not off");

    property p_div16_high;
        (act_div_r == DCPC_DIV_16 && $rose(forwarded_data_clock)
            && !commit_edge)
            ##1 (!commit_edge) [*8] |-> $fell(forwarded_data_clock);
    endproperty
    a_div16_high: assert property (p_div16_high) else $error("div16 bad");

    property p_fixed_high_readback;
        (cfg_rd && cfg_addr == DCPC_ADDR_DIV) |=> cfg_rdata[3:0] == 4'hF;
    endproperty
    a_fixed_high_readback: assert property (p_fixed_high_readback) else $error("low bits not fixed_high_readback");

    property p_samp_phase;
        $rose(input_sampling_clock) && $stable(act_samp_r)
            && $past(act_samp_r, 2) == act_samp_r
            |-> $past(base_cnt_r) == act_samp_r;
    endproperty
    a_samp_phase: assert property (p_samp_phase) else $error("samp phase");

    property p_samp_step;
        $rose(input_sampling_clock) && samp_quiet_r >= 5'h14
            |-> $past(input_sampling_clock, 16)
            && !$past(input_sampling_clock, 17);
    endproperty
    a_samp_step: assert property (p_samp_step) else $error("samp period");

    property p_sync_phase;
        $rose(datapath_sync_clock) && $stable(act_sync_r)
            && $past(act_sync_r, 2) == act_sync_r
            |-> $past(base_cnt_r) == act_sync_r;
    endproperty
    a_sync_phase: assert property (p_sync_phase) else $error("sync phase");

    property p_hold;
        !commit_edge |=> $stable(act_div_r) && $stable(act_samp_r)
            && $stable(act_sync_r);
    endproperty
    a_hold: assert property (p_hold) else $error("applied w/o commit");

    property p_rsvd;
        (cfg_rd && cfg_addr == DCPC_ADDR_DIV) |=> !cfg_rdata[7];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_invalid_low;
        divider_invalid [*2] |-> !forwarded_data_clock;
    endproperty
    a_invalid_low: assert property (p_invalid_low) else $error("invalid clk");

    c_commit: cover property (commit_edge);
    c_div64: cover property (act_div_r == DCPC_DIV_64 && $rose(fwd_clk_r));
    c_last_phase: cover property (act_samp_r == 4'hF && act_sync_r == 4'h0);
endmodule : dcpc_top
